// ---- hdl/sbsc_pkg.sv ----
// constants, types and operation summary of the burst sram control logic
// Overview of operation
// - selected, load, write high on a taken edge: latch address, start read burst.
// - advance on a taken edge: step the burst counter and continue the previous cycle.
// - read with output enable high does nothing visible; bus stays high-impedance.
// - selected, load, write low with lanes: latch address, start write of those lanes.
// - write strobe low without lanes writes nothing, bus high-impedance, also in bursts.
// - load with any chip select inactive gives a deselect with high-impedance bus.
// - advance continues deselect only after a deselect or reset; never entered from a read or write.
// - clock gate high: edge ignored, address and state held.
// - stalled edge keeps a driven read driven and a write high-impedance.
// - output drivers are off during write cycles whatever output enable does.
// - all outputs high-impedance from power-up.
// - two-bit burst counter wraps to the loaded value after four accesses.
// - order select low: linear burst, low bits step by one modulo four.
// - order select high: interleaved burst, start value xor step count.
// - flow-through when its select is low, pipeline when high; sleep defaults inactive.
// - sleep six edges after request rises (two once synchronised), state kept, resume after recovery.
// - asleep: deselected, inputs but sleep ignored, outputs high-impedance.
// - inputs sampled on rising edge; output enable and sleep act asynchronously.
// - pipeline read data one edge after access; flow-through one cycle sooner.
// - each active-low lane write covers one nine-bit byte; any lane mix allowed.
package sbsc_pkg;
  localparam int ADDR_W    = 18;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int BURST_W   = 2;
  localparam int FIFO_DEPTH = 4;

  localparam int CLK_PERIOD_NS      = 50;
  localparam int SLEEP_ENTRY_CYC    = 2;
  localparam int SLEEP_RECOVERY_NS  = 100;
  localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_CNT_W        = 4;

  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [BURST_W-1:0] STEP_ONE   = 2'h1;
  localparam logic [BURST_W-1:0] STEP_ZERO  = 2'h0;

  typedef enum logic [1:0] {
    OP_NONE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10,
    OP_DESEL = 2'b11
  } sbsc_op_e;

  typedef struct packed {
    sbsc_op_e          op;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
  } sbsc_stage_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;
    logic [DATA_W-1:0] data;
  } sbsc_wr_word_s;

  localparam int WR_WORD_W = ADDR_W + LANES + DATA_W;
endpackage

// ---- hdl/sbsc_fifo.sv ----
// small valid/ready fifo carrying write words toward the array
`timescale 1ns/1ps
`default_nettype none
module sbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr[PW-1:0]];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end
endmodule // sbsc_fifo
`default_nettype wire

// ---- hdl/sbsc_ctrl.sv ----
// cycle decode, burst counter, data pipeline and sleep control of the burst sram
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl (
  input  wire logic                              clk_sys_i,
  input  wire logic                              reset_n_i,
  input  wire logic [sbsc_pkg::ADDR_W-1:0]       addr_i,
  input  wire logic                              clk_gate_n_i,
  input  wire logic                              load_or_advance_i,
  input  wire logic                              write_n_i,
  input  wire logic [sbsc_pkg::LANES-1:0]        byte_lane_write_n_i,
  input  wire logic                              chip_sel_first_n_i,
  input  wire logic                              chip_sel_second_i,
  input  wire logic                              chip_sel_third_n_i,
  input  wire logic                              out_en_n_i,
  input  wire logic                              sleep_request_i,
  input  wire logic                              flow_through_sel_n_i,
  input  wire logic                              burst_order_sel_n_i,
  input  wire logic [sbsc_pkg::DATA_W-1:0]       dq_i,
  output logic      [sbsc_pkg::DATA_W-1:0]       dq_o,
  output logic                                   dq_oe_o,
  output logic      [sbsc_pkg::ADDR_W-1:0]       core_rd_addr_o,
  output logic                                   core_rd_o,
  input  wire logic [sbsc_pkg::DATA_W-1:0]       core_rdata_i,
  output logic                                   core_wr_valid_o,
  input  wire logic                              core_wr_ready_i,
  output var sbsc_pkg::sbsc_wr_word_s            core_wr_o,
  output logic                                   write_buf_ready_o,
  output logic                                   asleep_o
);
  logic [1:0]                          rst_ff;
  logic                                rst_n;
  logic [2:0]                          sleep_ff;
  logic                                sleep_level;
  logic [sbsc_pkg::SLEEP_CNT_W-1:0]    sleep_cnt;
  logic                                asleep;
  logic                                take;
  logic                                flow_mode;
  logic                                selected;
  sbsc_pkg::sbsc_op_e                  last_op;
  logic [sbsc_pkg::ADDR_W-1:0]         burst_base;
  logic [sbsc_pkg::BURST_W-1:0]        burst_step;
  logic [sbsc_pkg::BURST_W-1:0]        next_step;
  sbsc_pkg::sbsc_stage_s               next_stage;
  sbsc_pkg::sbsc_stage_s               stage1;
  sbsc_pkg::sbsc_stage_s               stage2;
  sbsc_pkg::sbsc_stage_s               out_stage;
  sbsc_pkg::sbsc_stage_s               wr_stage;
  logic [sbsc_pkg::DATA_W-1:0]         rdata1;
  logic [sbsc_pkg::DATA_W-1:0]         rdata2;
  sbsc_pkg::sbsc_wr_word_s             wr_word;
  logic                                wr_push;
  logic                                wr_ready;

  // burst address low bits for a given start and step count
  function automatic logic [sbsc_pkg::BURST_W-1:0] burst_low(
    input logic [sbsc_pkg::BURST_W-1:0] start,
    input logic [sbsc_pkg::BURST_W-1:0] step,
    input logic                         interleave
  );
    burst_low = interleave ? (start ^ step) : 2'(start + step);
  endfunction

  // reset release through two flops; the assertion edge stays asynchronous
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_ff <= 2'b00;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // sleep request is asynchronous; a change counts once the last two stages agree
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sleep_ff    <= 3'b000;
      sleep_level <= 1'b0;
    end else begin
      sleep_ff <= {sleep_ff[1:0], sleep_request_i};
      if (sleep_ff[1] == sleep_ff[2]) begin
        sleep_level <= sleep_ff[2];
      end
    end
  end

  // sleep entry after two cycles of request, exit after the recovery count
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sleep_cnt <= '0;
      asleep    <= 1'b0;
    end else if (sleep_level != asleep) begin
      if (!asleep && sleep_cnt == 4'(sbsc_pkg::SLEEP_ENTRY_CYC - 1)) begin
        asleep    <= 1'b1;
        sleep_cnt <= '0;
      end else if (asleep && sleep_cnt == 4'(sbsc_pkg::SLEEP_RECOVERY_CYC - 1)) begin
        asleep    <= 1'b0;
        sleep_cnt <= '0;
      end else begin
        sleep_cnt <= sleep_cnt + 4'h1;
      end
    end else begin
      sleep_cnt <= '0;
    end
  end
  assign asleep_o = asleep;

  // while asleep every edge is treated like a stall so internal state survives
  assign take      = !clk_gate_n_i && !asleep && rst_n;
  // the strap pin is pulled high when open, which selects pipeline
  assign flow_mode = !flow_through_sel_n_i;
  assign selected  = !chip_sel_first_n_i && chip_sel_second_i && !chip_sel_third_n_i;

  // cycle decode of the synchronous control inputs
  always_comb begin
    next_stage = '{op: sbsc_pkg::OP_DESEL, addr: addr_i, lanes: sbsc_pkg::LANES_NONE};
    next_step  = sbsc_pkg::STEP_ZERO;
    if (!load_or_advance_i) begin
      if (!selected) begin
        next_stage.op = sbsc_pkg::OP_DESEL;
      end else if (write_n_i) begin
        next_stage.op = sbsc_pkg::OP_READ;
      end else if (byte_lane_write_n_i == ~sbsc_pkg::LANES_NONE) begin
        next_stage.op = sbsc_pkg::OP_DESEL;
      end else begin
        next_stage.op    = sbsc_pkg::OP_WRITE;
        next_stage.lanes = ~byte_lane_write_n_i;
      end
    end else begin
      next_step       = 2'(burst_step + sbsc_pkg::STEP_ONE);
      next_stage.addr = {burst_base[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W],
                         burst_low(burst_base[sbsc_pkg::BURST_W-1:0], next_step, burst_order_sel_n_i)};
      case (last_op)
        sbsc_pkg::OP_READ: begin
          next_stage.op = sbsc_pkg::OP_READ;
        end
        sbsc_pkg::OP_WRITE: begin
          next_stage.op    = sbsc_pkg::OP_WRITE;
          next_stage.lanes = ~byte_lane_write_n_i;
        end
        default: begin
          next_stage.op = sbsc_pkg::OP_DESEL;
        end
      endcase
    end
  end

  // burst state: base address kept at load, step count advanced on continue
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      last_op    <= sbsc_pkg::OP_NONE;
      burst_base <= '0;
      burst_step <= sbsc_pkg::STEP_ZERO;
    end else if (take) begin
      last_op    <= next_stage.op;
      burst_step <= next_step;
      if (!load_or_advance_i) begin
        burst_base <= addr_i;
      end
    end
  end

  // array read issued from the decode so the result is caught at the command edge
  assign core_rd_addr_o = next_stage.addr;
  assign core_rd_o      = take && next_stage.op == sbsc_pkg::OP_READ;

  // two-stage command and read-data pipeline; held on stalled edges
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '{op: sbsc_pkg::OP_NONE, addr: '0, lanes: '0};
      stage2 <= '{op: sbsc_pkg::OP_NONE, addr: '0, lanes: '0};
      rdata1 <= '0;
      rdata2 <= '0;
    end else if (take) begin
      stage1 <= next_stage;
      stage2 <= stage1;
      rdata1 <= core_rdata_i;
      rdata2 <= rdata1;
    end
  end

  // flow-through reads from the first stage, pipeline from the output register
  assign out_stage = flow_mode ? stage1 : stage2;
  assign dq_o      = flow_mode ? rdata1 : rdata2;
  // output enable gates the drivers without a clock; writes never drive
  assign dq_oe_o   = out_stage.op == sbsc_pkg::OP_READ && !out_en_n_i && !asleep && rst_n;

  // write data is taken one edge after the command in flow-through, two in pipeline
  assign wr_stage = flow_mode ? stage1 : stage2;
  assign wr_word  = '{addr: wr_stage.addr, lanes: wr_stage.lanes, data: dq_i};
  // an abort carries no lanes and is never queued; a full buffer drops the word
  assign wr_push  = take && wr_stage.op == sbsc_pkg::OP_WRITE && wr_stage.lanes != sbsc_pkg::LANES_NONE;

  sbsc_fifo #(
    .WIDTH (sbsc_pkg::WR_WORD_W),
    .DEPTH (sbsc_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (wr_push),
    .in_ready_o  (wr_ready),
    .in_data_i   (wr_word),
    .out_valid_o (core_wr_valid_o),
    .out_ready_i (core_wr_ready_i),
    .out_data_o  (core_wr_o)
  );
  assign write_buf_ready_o = wr_ready;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  a_flow_read_drive: assert property (
    (take && next_stage.op == sbsc_pkg::OP_READ && flow_mode) ##1 (!out_en_n_i && !asleep && flow_mode)
    |-> dq_oe_o && dq_o == $past(core_rdata_i))
    else $error("flow-through read not driven one cycle after access");

  a_pipe_read_lat: assert property (
    (take && next_stage.op == sbsc_pkg::OP_READ && !flow_mode) ##1 (take && !flow_mode)
    ##1 (!out_en_n_i && !asleep && !flow_mode) |-> dq_oe_o && dq_o == $past(core_rdata_i, 2))
    else $error("pipelined read data not on bus after second edge");

  a_oe_high_hiz: assert property (out_en_n_i |-> !dq_oe_o)
    else $error("bus driven while output enable is high");

  a_write_no_drive: assert property (out_stage.op == sbsc_pkg::OP_WRITE |-> !dq_oe_o)
    else $error("bus driven during a write cycle");

  a_stall_hold_state: assert property (
    (!take && $past(take)) |=> $stable(stage1) && $stable(stage2) && $stable(burst_step) && $stable(burst_base))
    else $error("state changed on an ignored edge");

  a_upper_addr_hold: assert property (
    (take && !load_or_advance_i) ##1 (take && load_or_advance_i)
    |-> core_rd_addr_o[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W] == $past(addr_i[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W]))
    else $error("upper address bits moved during a burst");

  a_burst_order_step: assert property (
    (take && load_or_advance_i) |-> (burst_order_sel_n_i
      ? ((next_stage.addr[1:0] ^ burst_base[1:0]) == 2'(burst_step + 2'h1))
      : (2'(next_stage.addr[1:0] - burst_base[1:0]) == 2'(burst_step + 2'h1))))
    else $error("burst address does not follow the selected order");

  a_burst_wraps_back: assert property (
    (take && !load_or_advance_i && selected) ##1 (take && load_or_advance_i)[*4]
    |-> next_stage.addr[1:0] == $past(addr_i[1:0], 4) || !take)
    else $error("burst did not wrap to the loaded address after four");

  a_desel_continue: assert property (
    (take && load_or_advance_i) |-> ((next_stage.op == sbsc_pkg::OP_DESEL)
      == (last_op == sbsc_pkg::OP_DESEL || last_op == sbsc_pkg::OP_NONE)))
    else $error("deselect continue entered from a non-deselect cycle");

  a_sleep_entry: assert property (
    (sleep_level && !asleep)[*2] |=> asleep)
    else $error("sleep not entered two cycles after request");

  a_sleep_quiet: assert property (asleep |-> !dq_oe_o && !core_rd_o && !wr_push)
    else $error("activity while asleep");

  // an abort inside a write burst keeps the burst going but must never queue a word
  a_abort_no_write: assert property (
    (take && load_or_advance_i && last_op == sbsc_pkg::OP_WRITE
      && byte_lane_write_n_i == ~sbsc_pkg::LANES_NONE)
    ##1 take ##1 take
    |-> (flow_mode ? !$past(wr_push) : !wr_push))
    else $error("aborted write reached the buffer");

  // this one must keep watching while reset is held, so it opts out of the default disable
  a_reset_hiz: assert property (disable iff (1'b0)
    !rst_n |-> !dq_oe_o && !core_rd_o && !core_wr_valid_o && !asleep_o)
    else $error("output active while reset is held");

  a_pipe_write_lat: assert property (
    (take && next_stage.op == sbsc_pkg::OP_WRITE && next_stage.lanes != sbsc_pkg::LANES_NONE && !flow_mode)
    ##1 take ##1 (take && !flow_mode) |-> wr_push)
    else $error("pipelined write not queued at third edge");

  a_flow_write_lat: assert property (
    (take && next_stage.op == sbsc_pkg::OP_WRITE && next_stage.lanes != sbsc_pkg::LANES_NONE && flow_mode)
    ##1 (take && flow_mode) |-> wr_push)
    else $error("flow-through write not queued at second edge");

  a_desel_hiz: assert property (
    (take && !load_or_advance_i && !selected && flow_mode) ##1 flow_mode |-> !dq_oe_o)
    else $error("bus driven after a deselect");

  // a stall must not let the bus float under a read in progress
  a_stall_keep_drive: assert property (
    (dq_oe_o && !take) ##1 (!out_en_n_i && !asleep) |-> dq_oe_o)
    else $error("read drive dropped on a stalled edge");

  a_sleep_exit: assert property (
    (!sleep_level && asleep)[*2] |=> !asleep)
    else $error("sleep not left after the recovery count");

  // main scenarios that the bench is expected to reach
  c_pipe_read: cover property ((take && next_stage.op == sbsc_pkg::OP_READ && !flow_mode) ##2 dq_oe_o);
  c_write_burst: cover property ((take && next_stage.op == sbsc_pkg::OP_WRITE) ##1 (take && load_or_advance_i)[*3]);
  c_stall_read: cover property (dq_oe_o && !take ##1 dq_oe_o);
  c_sleep_cycle: cover property ($rose(asleep) ##[1:50] $fell(asleep));
  c_flow_write: cover property ((take && next_stage.op == sbsc_pkg::OP_WRITE && flow_mode) ##1 wr_push);
endmodule // sbsc_ctrl
`default_nettype wire

// ---- dv/sbsc_array_model.sv ----
// memory array model answering the core read and write ports of the control logic
`timescale 1ns/1ps
`default_nettype none
module sbsc_array_model (
  input  wire logic                          clk_i,
  input  wire logic                          stall_i,
  input  wire logic [sbsc_pkg::ADDR_W-1:0]   rd_addr_i,
  input  wire logic                          rd_i,
  output logic      [sbsc_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                          wr_valid_i,
  output logic                               wr_ready_o,
  input  wire sbsc_pkg::sbsc_wr_word_s       wr_i
);
  logic [sbsc_pkg::DATA_W-1:0] mem [logic [sbsc_pkg::ADDR_W-1:0]];
  logic [sbsc_pkg::DATA_W-1:0] v;
  logic                        upd = 1'b0;

  function automatic logic [sbsc_pkg::DATA_W-1:0] peek(input logic [sbsc_pkg::ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : {a, a};
  endfunction

  // outside a read strobe the inverse shows, so a stale capture cannot pass
  always @(rd_addr_i or rd_i or upd) rdata_o = rd_i ? peek(rd_addr_i) : ~peek(rd_addr_i);

  // ready held low lets the bench fill the write buffer
  assign wr_ready_o = !stall_i;

  always @(posedge clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      v = peek(wr_i.addr);
      for (int l = 0; l < sbsc_pkg::LANES; l++) begin
        if (wr_i.lanes[l]) v[l*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] = wr_i.data[l*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W];
      end
      mem[wr_i.addr] = v;
      upd = !upd;
    end
  end
endmodule // sbsc_array_model
`default_nettype wire

// ---- dv/sbsc_ctrl_tb.sv ----
// self-checking bench driving the burst sram control logic as its controller would
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl_tb;
  localparam int         CLK_NS = sbsc_pkg::CLK_PERIOD_NS;
  localparam logic [2:0] ACT    = 3'h2;
  localparam logic [2:0] OFF    = 3'h5;
  localparam logic [2:0] DES    = 3'h6;
  logic                        clk_sys_i = 1'b0;
  logic                        reset_n_i, clk_gate_n_i, load_or_advance_i, write_n_i, out_en_n_i;
  logic                        chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i, sleep_request_i;
  logic                        flow_through_sel_n_i, burst_order_sel_n_i, dq_oe_o, core_rd_o, core_wr_valid_o;
  logic                        core_wr_ready_i, write_buf_ready_o, asleep_o, stall_m;
  logic [sbsc_pkg::ADDR_W-1:0] addr_i, core_rd_addr_o;
  logic [sbsc_pkg::DATA_W-1:0] dq_i, dq_o, core_rdata_i;
  logic [sbsc_pkg::LANES-1:0]  byte_lane_write_n_i;
  sbsc_pkg::sbsc_wr_word_s     core_wr_o;
  int                          err_total, tests_run, n;
  logic [sbsc_pkg::DATA_W-1:0] sh [logic [sbsc_pkg::ADDR_W-1:0]];

  always #(CLK_NS/2) clk_sys_i = ~clk_sys_i;

  sbsc_ctrl dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .clk_gate_n_i(clk_gate_n_i),
    .load_or_advance_i(load_or_advance_i), .write_n_i(write_n_i), .byte_lane_write_n_i(byte_lane_write_n_i),
    .chip_sel_first_n_i(chip_sel_first_n_i), .chip_sel_second_i(chip_sel_second_i),
    .chip_sel_third_n_i(chip_sel_third_n_i), .out_en_n_i(out_en_n_i), .sleep_request_i(sleep_request_i),
    .flow_through_sel_n_i(flow_through_sel_n_i), .burst_order_sel_n_i(burst_order_sel_n_i), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe_o), .core_rd_addr_o(core_rd_addr_o), .core_rd_o(core_rd_o),
    .core_rdata_i(core_rdata_i), .core_wr_valid_o(core_wr_valid_o), .core_wr_ready_i(core_wr_ready_i),
    .core_wr_o(core_wr_o), .write_buf_ready_o(write_buf_ready_o), .asleep_o(asleep_o));

  sbsc_array_model model_u (.clk_i(clk_sys_i), .stall_i(stall_m), .rd_addr_i(core_rd_addr_o), .rd_i(core_rd_o),
    .rdata_o(core_rdata_i), .wr_valid_i(core_wr_valid_o), .wr_ready_o(core_wr_ready_i), .wr_i(core_wr_o));

  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [35:0] exp_rd(input logic [17:0] a);
    return sh.exists(a) ? sh[a] : {a, a};
  endfunction

  function automatic logic [17:0] baddr(input logic [17:0] a, input int k, input logic inter);
    return {a[17:2], inter ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)};
  endfunction

  // one bus cycle: inputs change just after an edge and are taken at the next
  task automatic step(input logic g, ld, w, input logic [3:0] bn, input logic [2:0] cs,
                      input logic [17:0] a, input logic [35:0] d);
    @(posedge clk_sys_i);
    clk_gate_n_i <= g;
    load_or_advance_i <= ld;
    write_n_i <= w;
    byte_lane_write_n_i <= bn;
    {chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i} <= cs;
    addr_i <= a;
    dq_i <= d;
    #1;
  endtask

  task automatic idle(input int k);
    repeat (k) step(1'b0, 1'b0, 1'b1, 4'hf, DES, 18'h0_0000, 36'h0_0000_0000);
  endtask

  task automatic mode(input logic inter, ft, oe_n);
    @(posedge clk_sys_i);
    burst_order_sel_n_i <= inter;
    flow_through_sel_n_i <= ft;
    out_en_n_i <= oe_n;
  endtask

  task automatic rd_burst(input logic [17:0] a, input logic inter, oe_n, ft, stl);
    logic [35:0] last;
    int          lat;
    lat = ft ? 2 : 1;
    last = '0;
    mode(inter, ft, oe_n);
    for (int i = 0; i < 4 + lat; i++) begin
      if (stl && i == 3) begin
        // a write command on a gated edge must be ignored entirely
        step(1'b1, 1'b0, 1'b0, 4'h0, ACT, ~a, ~last);
      end
      if (i == 0) step(1'b0, 1'b0, 1'b1, 4'h0, ACT, a, '0);
      else if (i < 4) step(1'b0, 1'b1, 1'b0, 4'h0, OFF, ~a, '0);
      else idle(1);
      if (i >= lat) begin
        last = exp_rd(baddr(a, i - lat, inter));
        chk("rd_oe", dq_oe_o, !oe_n);
        if (!oe_n) chk("rd_dq", dq_o, last);
        if (stl && i == 3) begin
          // the gated edge lies just behind, so the word of the edge before must still stand
          chk("stall_oe", dq_oe_o, 1'b1);
          chk("stall_dq", dq_o, last);
        end
      end
    end
    idle(2);
    chk("desel_oe", dq_oe_o, 1'b0);
  endtask

  task automatic wr_burst(input logic [17:0] a, input logic inter, input logic [15:0] lanes_n, input logic ft);
    logic [35:0] d;
    logic [35:0] v;
    logic [17:0] ea;
    logic [3:0]  bn;
    int          wl;
    wl = ft ? 2 : 1;
    mode(inter, ft, 1'b0);
    for (int i = 0; i < 7; i++) begin
      // data trails its command by one edge in flow-through and by two in pipeline
      d = (i >= wl && i < wl + 4) ? 36'h5_a5a5_0000 + 36'(i) : 36'ha_5a5a_ffff;
      bn = (i < 4) ? lanes_n[4*i +: 4] : 4'hf;
      if (i == 0) step(1'b0, 1'b0, 1'b0, bn, ACT, a, d);
      else if (i < 4) step(1'b0, 1'b1, 1'b1, bn, OFF, ~a, d);
      else step(1'b0, 1'b0, 1'b1, 4'hf, DES, a, d);
      chk("wr_oe", dq_oe_o, 1'b0);
      if (i >= wl && i < wl + 4) begin
        ea = baddr(a, i - wl, inter);
        v = exp_rd(ea);
        for (int l = 0; l < 4; l++) if (!lanes_n[4*(i-wl)+l]) v[9*l +: 9] = d[9*l +: 9];
        sh[ea] = v;
      end
    end
  endtask

  task automatic drain;
    n = 0;
    while (core_wr_valid_o !== 1'b0 && n < 20) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk("drained", core_wr_valid_o, 1'b0);
    chk("buf_ready", write_buf_ready_o, 1'b1);
  endtask

  initial begin
    #(CLK_NS * 4000);
    err_total++;
    finish_test;
  end

  initial begin
    reset_n_i = 1'b0;
    clk_gate_n_i = 1'b1;
    load_or_advance_i = 1'b0;
    write_n_i = 1'b1;
    byte_lane_write_n_i = 4'hf;
    {chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i} = DES;
    out_en_n_i = 1'b0;
    sleep_request_i = 1'b0;
    flow_through_sel_n_i = 1'b1;
    burst_order_sel_n_i = 1'b0;
    addr_i = '0;
    dq_i = '0;
    stall_m = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_sys_i);
    chk("rst_oe", dq_oe_o, 1'b0);
    reset_n_i <= 1'b1;
    idle(2);
    repeat (2) begin
      step(1'b0, 1'b1, 1'b1, 4'h0, ACT, 18'h0_0005, '0);
      chk("cont_rd", core_rd_o, 1'b0);
    end
    for (int k = 0; k < 3; k++) begin
      step(1'b0, 1'b0, 1'b1, 4'h0, (k == 0) ? 3'h6 : (k == 1) ? 3'h0 : 3'h3, 18'h0_0009, '0);
      chk("desel_rd", core_rd_o, 1'b0);
      step(1'b0, 1'b1, 1'b1, 4'h0, ACT, 18'h0_0009, '0);
      chk("desel_cont", core_rd_o, 1'b0);
      chk("desel_oe", dq_oe_o, 1'b0);
    end
    rd_burst(18'h1_0001, 1'b0, 1'b0, 1'b1, 1'b1);
    rd_burst(18'h0_2343, 1'b1, 1'b0, 1'b1, 1'b0);
    rd_burst(18'h3_0002, 1'b0, 1'b0, 1'b0, 1'b0);
    rd_burst(18'h0_0400, 1'b1, 1'b1, 1'b1, 1'b0);
    @(posedge clk_sys_i);
    stall_m <= 1'b1;
    wr_burst(18'h0_1235, 1'b0, 16'h75a0, 1'b1);
    chk("buf_full", write_buf_ready_o, 1'b0);
    @(posedge clk_sys_i);
    stall_m <= 1'b0;
    drain;
    rd_burst(18'h0_1235, 1'b0, 1'b0, 1'b1, 1'b0);
    wr_burst(18'h2_abcf, 1'b1, 16'hc0fe, 1'b0);
    drain;
    rd_burst(18'h2_abcf, 1'b1, 1'b0, 1'b1, 1'b0);
    // raised only with nothing pending
    @(posedge clk_sys_i);
    sleep_request_i <= 1'b1;
    idle(2);
    chk("sleep_early", asleep_o, 1'b0);
    n = 0;
    while (asleep_o !== 1'b1 && n < 8) begin
      idle(1);
      n++;
    end
    chk("asleep", asleep_o, 1'b1);
    step(1'b0, 1'b0, 1'b1, 4'h0, ACT, 18'h0_0777, '0);
    chk("sleep_rd", core_rd_o, 1'b0);
    idle(2);
    chk("sleep_oe", dq_oe_o, 1'b0);
    @(posedge clk_sys_i);
    sleep_request_i <= 1'b0;
    n = 0;
    while (asleep_o !== 1'b0 && n < 8) begin
      idle(1);
      n++;
    end
    chk("awake", asleep_o, 1'b0);
    rd_burst(18'h0_0777, 1'b0, 1'b0, 1'b1, 1'b0);
    finish_test;
  end
endmodule // sbsc_ctrl_tb
`default_nettype wire
